/* design/pps_pkg.sv */
// package for the phy port selection block: register map, fields, timing
// assumes a 250 MHz system clock and a 32-bit classic wishbone register bus
`default_nettype none

package pps_pkg;

  // register map
  localparam logic [7:0]  HWCFG_OFFSET      = 8'h74;
  localparam logic [31:0] HWCFG_RESET       = 32'h0000_0000;

  // field positions in hardware_configuration
  localparam int          SOFT_RESET_TRIGGER_TRIG_BIT     = 0;
  localparam int          SOFT_RESET_TIMEOUT_FLAG_BIT       = 1;
  localparam int          PORT_EN_BIT       = 2;
  localparam int          STRAP_BIT         = 3;
  localparam int          MGMT_SEL_BIT      = 4;
  localparam int          CLK_SEL_LSB       = 5;
  localparam int          CLK_SEL_MSB       = 6;

  // field reset values
  localparam logic [1:0]  CLK_SEL_RESET     = 2'h0;
  localparam logic        MGMT_SEL_RESET    = 1'h0;
  localparam logic        PORT_EN_RESET     = 1'h0;
  localparam logic        SOFT_RESET_TIMEOUT_FLAG_RESET     = 1'h0;

  // mii clock source encodings
  localparam logic [1:0]  CLK_SRC_INT       = 2'h0;
  localparam logic [1:0]  CLK_SRC_EXT       = 2'h1;
  localparam logic [1:0]  CLK_SRC_OFF       = 2'h2;
  localparam logic [1:0]  CLK_SRC_INT_ALT   = 2'h3;

  // timing
  localparam int          CLK_PERIOD_PS     = 4000;
  localparam int          CLK_IDLE_NS       = 1000;
  localparam int          SOFT_RESET_TRIGGER_TIMEOUT_NS   = 2000;
  localparam int          CLK_IDLE_CYCLES   = (CLK_IDLE_NS * 1000) / CLK_PERIOD_PS;
  localparam int          SOFT_RESET_TRIGGER_TIMEOUT_CYC  = (SOFT_RESET_TRIGGER_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
  localparam int          CNT_W             = 10;

  // pin filter channels
  localparam int          NUM_WATCH         = 5;
  localparam int          W_INT_RX          = 0;
  localparam int          W_INT_TX          = 1;
  localparam int          W_EXT_RX          = 2;
  localparam int          W_EXT_TX          = 3;
  localparam int          W_EXT_MDIO        = 4;

  // soft reset sequencer
  typedef enum logic [0:0] {
    PPS_SR_IDLE,
    PPS_SR_WAIT
  } pps_sr_state_t;

endpackage : pps_pkg

`default_nettype wire

/* design/pps_pin_watch.sv */
// three-flop pin filter with edge-based activity detector
// assumes pin_i is asynchronous to clk_i; reset is synchronous
`default_nettype none

module pps_pin_watch
  import pps_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // pin
  input  wire logic pin_i,
  // filtered view
  output logic      level_o,
  output logic      running_o
);

  logic             sync1;
  logic             sync2;
  logic             sync3;
  logic [CNT_W-1:0] idle_cnt;
  logic [CNT_W-1:0] next_idle_cnt;
  logic             next_level;
  logic             next_running;

  // synchroniser, left unreset so it settles during reset
  always_ff @(posedge clk_i) begin
    sync1 <= pin_i;
    sync2 <= sync1;
    sync3 <= sync2;
  end

  always_comb begin
    next_level    = level_o;
    next_idle_cnt = idle_cnt;
    if ((sync2 == sync3) && (sync3 != level_o)) begin
      next_level    = sync3;
      next_idle_cnt = '0;
    end else if (idle_cnt != CNT_W'(CLK_IDLE_CYCLES)) begin
      next_idle_cnt = idle_cnt + CNT_W'(1);
    end
    next_running = (next_idle_cnt != CNT_W'(CLK_IDLE_CYCLES));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // level tracks the settled pin in reset: strap sees it, no false edge
      level_o   <= sync3;
      idle_cnt  <= CNT_W'(CLK_IDLE_CYCLES);
      running_o <= 1'b0;
    end else begin
      level_o   <= next_level;
      idle_cnt  <= next_idle_cnt;
      running_o <= next_running;
    end
  end

endmodule // pps_pin_watch

`default_nettype wire

/* design/pps_port_select.sv */
// phy port selection: mii clock source, management port routing, external
// port enable, external phy strap and soft reset timeout, behind one register
// assumes a classic wishbone master on clk_i and pins asynchronous to clk_i
//
// Design decisions made here: the Wishbone register port and the placing of the registers.
`default_nettype none

module pps_port_select
  import pps_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_ack_o,
  output logic [31:0]      wb_dat_o,
  // mii clocks from the two phys
  input  wire logic        int_rx_clk_i,
  input  wire logic        int_tx_clk_i,
  input  wire logic        ext_rx_clk_i,
  input  wire logic        ext_tx_clk_i,
  // mii clocks to the mac
  output logic             mac_rx_clk_o,
  output logic             mac_tx_clk_o,
  // management master on the mac side
  input  wire logic        mac_mdc_i,
  input  wire logic        mac_mdio_i,
  input  wire logic        mac_mdio_oe_i,
  output logic             mac_mdio_o,
  // internal phy management
  input  wire logic        int_mdio_i,
  output logic             int_mdc_o,
  output logic             int_mdio_o,
  output logic             int_mdio_oe_o,
  // external management pins
  input  wire logic        ext_mdio_i,
  output logic             ext_mdc_o,
  output logic             ext_mdio_o,
  output logic             ext_mdio_oe_o,
  // port enables
  output logic             ext_port_en_o,
  output logic             int_phy_en_o,
  // soft reset to controller registers
  output logic             soft_reset_o
);

  import pps_pkg::*;

  // pin filters
  logic [NUM_WATCH-1:0] watch_pin;
  logic [NUM_WATCH-1:0] watch_level;
  logic [NUM_WATCH-1:0] watch_running;

  assign watch_pin[W_INT_RX]   = int_rx_clk_i;
  assign watch_pin[W_INT_TX]   = int_tx_clk_i;
  assign watch_pin[W_EXT_RX]   = ext_rx_clk_i;
  assign watch_pin[W_EXT_TX]   = ext_tx_clk_i;
  assign watch_pin[W_EXT_MDIO] = ext_mdio_i;

  generate
    for (genvar g = 0; g < NUM_WATCH; g++) begin : g_watch
      pps_pin_watch u_watch (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .pin_i     (watch_pin[g]),
        .level_o   (watch_level[g]),
        .running_o (watch_running[g])
      );
    end
  endgenerate

  // register state
  logic [1:0]       mii_clock_source_select;
  logic             mgmt_port_target_select;
  logic             outside_phy_port_enable;
  logic             outside_phy_present_strap;
  logic             soft_reset_timeout_flag;
  logic             strap_pending;
  pps_sr_state_t    sr_state;
  logic [CNT_W-1:0] sr_cnt;
  logic             wb_ack;
  logic [31:0]      wb_dat;
  logic             soft_reset;

  logic [1:0]       next_mii_clock_source_select;
  logic             next_mgmt_port_target_select;
  logic             next_outside_phy_port_enable;
  logic             next_outside_phy_present_strap;
  logic             next_soft_reset_timeout_flag;
  logic             next_strap_pending;
  pps_sr_state_t    next_sr_state;
  logic [CNT_W-1:0] next_sr_cnt;
  logic             next_wb_ack;
  logic [31:0]      next_wb_dat;
  logic             next_soft_reset;

  logic             bus_req;
  logic             hit;
  logic             wr_low;
  logic             int_clks_run;
  logic [31:0]      read_word;

  assign bus_req      = wb_cyc_i && wb_stb_i && !wb_ack;
  assign hit          = (wb_adr_i == HWCFG_OFFSET);
  assign wr_low       = bus_req && hit && wb_we_i && wb_sel_i[0];
  assign int_clks_run = watch_running[W_INT_RX] && watch_running[W_INT_TX];

  // read view, reserved bits zero
  always_comb begin
    read_word                            = '0;
    read_word[CLK_SEL_MSB:CLK_SEL_LSB]   = mii_clock_source_select;
    read_word[MGMT_SEL_BIT]              = mgmt_port_target_select;
    read_word[STRAP_BIT]                 = outside_phy_present_strap;
    read_word[PORT_EN_BIT]               = outside_phy_port_enable;
    read_word[SOFT_RESET_TIMEOUT_FLAG_BIT]               = soft_reset_timeout_flag;
    read_word[SOFT_RESET_TRIGGER_TRIG_BIT]             = (sr_state == PPS_SR_WAIT);
  end

  // register file and soft reset sequencer
  always_comb begin
    next_mii_clock_source_select   = mii_clock_source_select;
    next_mgmt_port_target_select   = mgmt_port_target_select;
    next_outside_phy_port_enable   = outside_phy_port_enable;
    next_outside_phy_present_strap = outside_phy_present_strap;
    next_soft_reset_timeout_flag   = soft_reset_timeout_flag;
    next_strap_pending             = 1'b0;
    next_sr_state                  = sr_state;
    next_sr_cnt                    = sr_cnt;
    next_soft_reset                = 1'b0;
    next_wb_ack                    = bus_req;
    next_wb_dat                    = '0;

    // strap caught on first edge after reset release
    if (strap_pending) begin
      next_outside_phy_present_strap = watch_level[W_EXT_MDIO];
    end

    if (bus_req && hit && !wb_we_i) begin
      next_wb_dat = read_word;
    end

    if (wr_low) begin
      next_mii_clock_source_select = wb_dat_i[CLK_SEL_MSB:CLK_SEL_LSB];
      next_mgmt_port_target_select = wb_dat_i[MGMT_SEL_BIT];
      next_outside_phy_port_enable = wb_dat_i[PORT_EN_BIT];
    end

    case (sr_state)
      PPS_SR_IDLE: begin
        if (wr_low && wb_dat_i[SOFT_RESET_TRIGGER_TRIG_BIT]) begin
          next_sr_state                = PPS_SR_WAIT;
          next_sr_cnt                  = '0;
          next_soft_reset_timeout_flag = 1'b0;
        end
      end
      PPS_SR_WAIT: begin
        if (int_clks_run) begin
          next_soft_reset = 1'b1;
          next_sr_state   = PPS_SR_IDLE;
        end else if (sr_cnt == CNT_W'(SOFT_RESET_TRIGGER_TIMEOUT_CYC - 1)) begin
          next_soft_reset_timeout_flag = 1'b1;
          next_sr_state                = PPS_SR_IDLE;
        end else begin
          next_sr_cnt = sr_cnt + CNT_W'(1);
        end
      end
      default: begin
        next_sr_state = PPS_SR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mii_clock_source_select   <= CLK_SEL_RESET;
      mgmt_port_target_select   <= MGMT_SEL_RESET;
      outside_phy_port_enable   <= PORT_EN_RESET;
      outside_phy_present_strap <= 1'b0;
      soft_reset_timeout_flag   <= SOFT_RESET_TIMEOUT_FLAG_RESET;
      strap_pending             <= 1'b1;
      sr_state                  <= PPS_SR_IDLE;
      sr_cnt                    <= '0;
      wb_ack                    <= 1'b0;
      wb_dat                    <= HWCFG_RESET;
      soft_reset                <= 1'b0;
    end else begin
      mii_clock_source_select   <= next_mii_clock_source_select;
      mgmt_port_target_select   <= next_mgmt_port_target_select;
      outside_phy_port_enable   <= next_outside_phy_port_enable;
      outside_phy_present_strap <= next_outside_phy_present_strap;
      soft_reset_timeout_flag   <= next_soft_reset_timeout_flag;
      strap_pending             <= next_strap_pending;
      sr_state                  <= next_sr_state;
      sr_cnt                    <= next_sr_cnt;
      wb_ack                    <= next_wb_ack;
      wb_dat                    <= next_wb_dat;
      soft_reset                <= next_soft_reset;
    end
  end

  // routing outputs
  logic next_mac_rx_clk;
  logic next_mac_tx_clk;
  logic next_mac_mdio;
  logic next_int_mdc;
  logic next_int_mdio;
  logic next_int_mdio_oe;
  logic next_ext_mdc;
  logic next_ext_mdio;
  logic next_ext_mdio_oe;

  always_comb begin
    // clocks follow only the clock source field
    case (mii_clock_source_select)
      CLK_SRC_INT, CLK_SRC_INT_ALT: begin
        next_mac_rx_clk = watch_level[W_INT_RX];
        next_mac_tx_clk = watch_level[W_INT_TX];
      end
      CLK_SRC_EXT: begin
        next_mac_rx_clk = watch_level[W_EXT_RX];
        next_mac_tx_clk = watch_level[W_EXT_TX];
      end
      CLK_SRC_OFF: begin
        next_mac_rx_clk = 1'b0;
        next_mac_tx_clk = 1'b0;
      end
      default: begin
        next_mac_rx_clk = 1'b0;
        next_mac_tx_clk = 1'b0;
      end
    endcase

    // management follows only its own select, never the port enable
    if (mgmt_port_target_select) begin
      next_int_mdc     = 1'b0;
      next_int_mdio    = 1'b0;
      next_int_mdio_oe = 1'b1;
      next_ext_mdc     = mac_mdc_i;
      next_ext_mdio    = mac_mdio_i;
      next_ext_mdio_oe = mac_mdio_oe_i;
      next_mac_mdio    = watch_level[W_EXT_MDIO];
    end else begin
      next_int_mdc     = mac_mdc_i;
      next_int_mdio    = mac_mdio_i;
      next_int_mdio_oe = mac_mdio_oe_i;
      next_ext_mdc     = 1'b0;
      next_ext_mdio    = 1'b0;
      next_ext_mdio_oe = 1'b0;
      next_mac_mdio    = int_mdio_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mac_rx_clk_o  <= 1'b0;
      mac_tx_clk_o  <= 1'b0;
      mac_mdio_o    <= 1'b0;
      int_mdc_o     <= 1'b0;
      int_mdio_o    <= 1'b0;
      int_mdio_oe_o <= 1'b0;
      ext_mdc_o     <= 1'b0;
      ext_mdio_o    <= 1'b0;
      ext_mdio_oe_o <= 1'b0;
      ext_port_en_o <= 1'b0;
      int_phy_en_o  <= 1'b1;
    end else begin
      mac_rx_clk_o  <= next_mac_rx_clk;
      mac_tx_clk_o  <= next_mac_tx_clk;
      mac_mdio_o    <= next_mac_mdio;
      int_mdc_o     <= next_int_mdc;
      int_mdio_o    <= next_int_mdio;
      int_mdio_oe_o <= next_int_mdio_oe;
      ext_mdc_o     <= next_ext_mdc;
      ext_mdio_o    <= next_ext_mdio;
      ext_mdio_oe_o <= next_ext_mdio_oe;
      ext_port_en_o <= outside_phy_port_enable;
      int_phy_en_o  <= !outside_phy_port_enable;
    end
  end

  assign wb_ack_o     = wb_ack;
  assign wb_dat_o     = wb_dat;
  assign soft_reset_o = soft_reset;

endmodule // pps_port_select

`default_nettype wire

/* tb/pps_sva.sv */
// checker for pps_port_select: bus answer, management routing, enables, soft reset
// assumes it is bound to the design top; reset synchronous, active high
`default_nettype none

module pps_sva (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // management
  input wire logic        mac_mdc_i,
  input wire logic        int_mdc_o,
  input wire logic        int_mdio_o,
  input wire logic        int_mdio_oe_o,
  input wire logic        ext_mdc_o,
  input wire logic        ext_mdio_oe_o,
  // enables and soft reset
  input wire logic        ext_port_en_o,
  input wire logic        int_phy_en_o,
  input wire logic        soft_reset_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_ack_take; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_take: assert property (p_ack_take) else $error("request not answered next cycle");
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_rsv_zero; wb_ack_o |-> wb_dat_o[31:7] == 25'h0; endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits not zero");
  property p_int_held; ext_mdio_oe_o |-> int_mdio_oe_o && !int_mdio_o && !int_mdc_o; endproperty
  a_int_held: assert property (p_int_held) else $error("internal mgmt not held low");
  property p_ext_idle; int_mdc_o |-> !ext_mdc_o && !ext_mdio_oe_o; endproperty
  a_ext_idle: assert property (p_ext_idle) else $error("external mgmt not idle");
  property p_mdc_follow; int_mdc_o || ext_mdc_o |-> $past(mac_mdc_i); endproperty
  a_mdc_follow: assert property (p_mdc_follow) else $error("mdc not from mac");
  property p_en_excl; ext_port_en_o != int_phy_en_o; endproperty
  a_en_excl: assert property (p_en_excl) else $error("port enables not exclusive");
  property p_soft_reset_trigger_one; soft_reset_o |=> !soft_reset_o ##1 !soft_reset_o; endproperty
  a_soft_reset_trigger_one: assert property (p_soft_reset_trigger_one) else $error("soft reset not one pulse");

  c_write: cover property (wb_cyc_i && wb_we_i && wb_ack_o);
  c_soft_reset_trigger: cover property (soft_reset_o);
  c_ext_mgmt: cover property (ext_mdio_oe_o && ext_mdc_o);
  c_int_mgmt: cover property (int_mdc_o);
endmodule // pps_sva

bind pps_port_select pps_sva u_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .wb_dat_o,
  .mac_mdc_i, .int_mdc_o, .int_mdio_o, .int_mdio_oe_o, .ext_mdc_o, .ext_mdio_oe_o, .ext_port_en_o,
  .int_phy_en_o, .soft_reset_o);

`default_nettype wire

/* tb/pps_phy_model.sv */
// far side model: internal and external phy clocks and mdio line levels
// assumes pin enables are high while the design drives; runs set by the bench
`default_nettype none

module pps_phy_model #(
  parameter logic PULL = 1'b1
) (
  // run controls
  input  wire logic int_run_i,
  input  wire logic ext_run_i,
  // design management outputs
  input  wire logic int_mdio_i,
  input  wire logic int_mdio_oe_i,
  input  wire logic ext_mdio_i,
  input  wire logic ext_mdio_oe_i,
  // levels to the design
  output logic      int_rx_clk_o,
  output logic      int_tx_clk_o,
  output logic      ext_rx_clk_o,
  output logic      ext_tx_clk_o,
  output logic      ext_level_o,
  output logic      int_level_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // stopped clocks stand still low; edges kept off the system clock edges
  initial begin
    int_rx_clk_o = 1'b0;
    #1.3;
    forever #40 int_rx_clk_o = int_run_i ? ~int_rx_clk_o : 1'b0;
  end
  initial begin
    int_tx_clk_o = 1'b0;
    #21.7;
    forever #40 int_tx_clk_o = int_run_i ? ~int_tx_clk_o : 1'b0;
  end
  initial begin
    ext_rx_clk_o = 1'b0;
    #3.1;
    forever #40 ext_rx_clk_o = ext_run_i ? ~ext_rx_clk_o : 1'b0;
  end
  initial begin
    ext_tx_clk_o = 1'b0;
    #23.3;
    forever #40 ext_tx_clk_o = ext_run_i ? ~ext_tx_clk_o : 1'b0;
  end
  // released pin falls to the pull level
  assign ext_level_o = ext_mdio_oe_i ? ext_mdio_i : PULL;
  // internal phy answers low when not driven
  assign int_level_o = int_mdio_oe_i ? int_mdio_i : 1'b0;
endmodule // pps_phy_model

`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for pps_port_select over classic wishbone
// assumes pps_pkg, the phy model and the bound checker are compiled first
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; $display("[ERR] %s exp %h got %h", nm, e, g); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pps_pkg::*;

  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, int_run, ext_run, act;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic        int_rx_clk_i, int_tx_clk_i, ext_rx_clk_i, ext_tx_clk_i, mac_rx_clk_o, mac_tx_clk_o;
  logic        mac_mdc_i, mac_mdio_i, mac_mdio_oe_i, mac_mdio_o, int_mdio_i, int_mdc_o, int_mdio_o, int_mdio_oe_o;
  logic        ext_mdio_i, ext_mdc_o, ext_mdio_o, ext_mdio_oe_o, ext_port_en_o, int_phy_en_o, soft_reset_o;
  int          bad_count, checks_done, pulses;

  pps_port_select DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_ack_o, .wb_dat_o, .int_rx_clk_i, .int_tx_clk_i, .ext_rx_clk_i, .ext_tx_clk_i, .mac_rx_clk_o,
    .mac_tx_clk_o, .mac_mdc_i, .mac_mdio_i, .mac_mdio_oe_i, .mac_mdio_o, .int_mdio_i, .int_mdc_o,
    .int_mdio_o, .int_mdio_oe_o, .ext_mdio_i, .ext_mdc_o, .ext_mdio_o, .ext_mdio_oe_o, .ext_port_en_o,
    .int_phy_en_o, .soft_reset_o);

  pps_phy_model #(.PULL(1'b1)) u_phy (.int_run_i(int_run), .ext_run_i(ext_run), .int_mdio_i(int_mdio_o),
    .int_mdio_oe_i(int_mdio_oe_o), .ext_mdio_i(ext_mdio_o), .ext_mdio_oe_i(ext_mdio_oe_o),
    .int_rx_clk_o(int_rx_clk_i), .int_tx_clk_o(int_tx_clk_i), .ext_rx_clk_o(ext_rx_clk_i),
    .ext_tx_clk_o(ext_tx_clk_i), .ext_level_o(ext_mdio_i), .int_level_o(int_mdio_i));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  always @(negedge clk_i) if (soft_reset_o === 1'b1) pulses++;

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // one classic cycle, entered just after a rising edge
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    `CHK("ack cycles", 2, n)
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    `CHK("read word", e, q)
  endtask

  // management write, then pins {ext mdc, ext oe, int mdc, int mdio, int oe, mac mdio, port en}
  task automatic mg(input logic [31:0] d, input logic [6:0] e);
    bus(1'b1, HWCFG_OFFSET, d, 4'hf);
    repeat (8) @(posedge clk_i);
    `CHK("mgmt pins", e, {ext_mdc_o, ext_mdio_oe_o, int_mdc_o, int_mdio_o, int_mdio_oe_o, mac_mdio_o, ext_port_en_o})
  endtask

  // both mac clocks toggle within the window
  task automatic watch(output logic on);
    int   nr;
    int   nt;
    logic pr;
    logic pt;
    nr = 0;
    nt = 0;
    repeat (20) @(negedge clk_i);
    pr = mac_rx_clk_o;
    pt = mac_tx_clk_o;
    repeat (100) begin
      @(negedge clk_i);
      nr += int'(mac_rx_clk_o !== pr);
      nt += int'(mac_tx_clk_o !== pt);
      pr = mac_rx_clk_o;
      pt = mac_tx_clk_o;
    end
    on = (nr > 0) && (nt > 0);
    @(posedge clk_i);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    $display("[ERR] watchdog exp done got hang");
    tally_and_finish();
  end

  initial begin
    {rst_i, mac_mdc_i, mac_mdio_i, mac_mdio_oe_i, int_run} = 5'h1f;
    {wb_cyc_i, wb_stb_i, wb_we_i, ext_run, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {bad_count, checks_done, pulses} = '0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd(HWCFG_OFFSET, 32'h0000_0008);
    bus(1'b1, HWCFG_OFFSET, 32'hffff_ff74, 4'hf);
    rd(HWCFG_OFFSET, 32'h0000_007c);
    bus(1'b1, 8'h78, 32'hffff_ffff, 4'hf);
    rd(8'h78, 32'h0);
    bus(1'b1, HWCFG_OFFSET, 32'h0, 4'he);
    rd(HWCFG_OFFSET, 32'h0000_007c);
    mg(32'h10, 7'h66);
    `CHK("ext mdio", 1'b1, ext_mdio_o)
    mac_mdio_oe_i <= 1'b0;
    mac_mdio_i <= 1'b0;
    mg(32'h14, 7'h47);
    `CHK("internal phy enable", 1'b0, int_phy_en_o)
    mg(32'h04, 7'h11);
    for (int p = 0; p < 2; p++) begin
      int_run <= (p == 0);
      ext_run <= (p == 1);
      for (int s = 0; s < 4; s++) begin
        bus(1'b1, HWCFG_OFFSET, {25'h0, s[1:0], 2'b00, p[0], 2'b00}, 4'hf);
        watch(act);
        `CHK("mac clocks", (p == 0) ? (s == 0 || s == 3) : (s == 1), act)
        `CHK("mdc route", 1'b1, int_mdc_o)
      end
    end
    int_run <= 1'b1;
    repeat (300) @(posedge clk_i);
    bus(1'b1, HWCFG_OFFSET, 32'h1, 4'hf);
    repeat (20) @(posedge clk_i);
    `CHK("soft resets", 1, pulses)
    rd(HWCFG_OFFSET, 32'h0000_0008);
    int_run <= 1'b0;
    repeat (300) @(posedge clk_i);
    bus(1'b1, HWCFG_OFFSET, 32'h1, 4'hf);
    rd(HWCFG_OFFSET, 32'h0000_0009);
    repeat (600) @(posedge clk_i);
    rd(HWCFG_OFFSET, 32'h0000_000a);
    `CHK("soft resets", 1, pulses)
    int_run <= 1'b1;
    repeat (300) @(posedge clk_i);
    bus(1'b1, HWCFG_OFFSET, 32'h1, 4'hf);
    repeat (20) @(posedge clk_i);
    `CHK("soft resets", 2, pulses)
    rd(HWCFG_OFFSET, 32'h0000_0008);
    tally_and_finish();
  end
endmodule // testbench

`default_nettype wire
